// >>> rtl/eprsq_pkg.sv
// Constants and types shared by the EPROM program and read sequencer
package eprsq_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ     = 25_000_000;
    localparam int unsigned SETTLE_US  = 1000;
    localparam int unsigned HOLD_MS    = 50;
    localparam int unsigned SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned HOLD_CYC   = HOLD_MS * (CLK_HZ / 1000);
    localparam int unsigned SYNC_WAIT  = 5;

    // Widths and depths
    localparam int unsigned ADDR_W      = 12;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned PROM_ADDR_W = 11;
    localparam int unsigned FIFO_DEPTH  = 8;
    localparam int unsigned SYNC_W      = 11;

    // Address limits and size select codes
    localparam logic [11:0] LIMIT_2K  = 12'h7ff;
    localparam logic [11:0] LIMIT_1K  = 12'h3ff;
    localparam logic [11:0] LIMIT_512 = 12'h1ff;
    localparam logic [1:0]  SIZE_2K   = 2'h0;
    localparam logic [1:0]  SIZE_1K   = 2'h1;

    // Reset values
    localparam logic [7:0]  ERASED_BYTE = 8'hff;
    localparam logic [10:0] SYNC_RST    = 11'h000;

    typedef struct packed {
        logic        burn;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } eprsq_req_t;

    typedef struct packed {
        logic       pass;
        logic       range_err;
        logic       hv_err;
        logic       verify_err;
        logic [7:0] rdata;
    } eprsq_res_t;

    localparam int unsigned REQ_W = $bits(eprsq_req_t);

    typedef enum logic [13:0] {
        ST_IDLE     = 14'h0001,
        ST_ADDR_CHK = 14'h0002,
        ST_RD_WAIT  = 14'h0004,
        ST_HV_CHK   = 14'h0008,
        ST_CS_PULSE = 14'h0010,
        ST_WDE_ON   = 14'h0020,
        ST_SETTLE   = 14'h0040,
        ST_HOLD     = 14'h0080,
        ST_BURN_OFF = 14'h0100,
        ST_WDE_OFF  = 14'h0200,
        ST_CS_LOW   = 14'h0400,
        ST_VFY_WAIT = 14'h0800,
        ST_VFY_CMP  = 14'h1000,
        ST_DONE     = 14'h2000
    } eprsq_state_t;

endpackage : eprsq_pkg

// >>> rtl/eprsq_fifo.sv
// Request FIFO with registered fill flags
`timescale 1ns/1ns
`default_nettype none
module eprsq_fifo #(
    parameter int unsigned WIDTH = 21,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             ref_clk_i,
    input  wire logic             reset_n_i,
    input  wire logic             in_valid_i,
    output var  logic             in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output var  logic             out_valid_o,
    input  wire logic             out_ready_i,
    output var  logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || WIDTH < 1) begin : g_bad_cfg
        $error("eprsq_fifo: DEPTH must be at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0]    cnt_q, cnt_d;
    logic             push, pop;
    logic             ready_d, valid_d;

    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : step

    always_comb begin
        push    = in_valid_i && in_ready_o;
        pop     = out_ready_i && out_valid_o;
        wr_d    = push ? step(wr_q) : wr_q;
        rd_d    = pop ? step(rd_q) : rd_q;
        cnt_d   = cnt_q + CW'(push) - CW'(pop);
        ready_d = cnt_d < CW'(DEPTH);
        valid_d = cnt_d != '0;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_q        <= '0;
            rd_q        <= '0;
            cnt_q       <= '0;
            in_ready_o  <= 1'b1;
            out_valid_o <= 1'b0;
        end else begin
            wr_q        <= wr_d;
            rd_q        <= rd_d;
            cnt_q       <= cnt_d;
            in_ready_o  <= ready_d;
            out_valid_o <= valid_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    assign out_data_o = mem_q[rd_q];

endmodule : eprsq_fifo
`default_nettype wire

// >>> rtl/eprsq_top.sv
// EPROM program and read sequencer, top level
// Operation
// (RULE1) Flag low when address exceeds selected size limit.
// (RULE2) Out-of-range address aborts read or program at once.
// (RULE3) Request bit chooses program entry or read entry.
// (RULE4) Board presents address, and write byte for program, beforehand.
// (RULE5) Read raises read-data enable and returns memory byte.
// (RULE6) Write-data enable high only inside a program operation.
// (RULE7) Write byte reaches data pins via open-collector drives.
// (RULE8) Missing high voltage aborts program before any pulse.
// (RULE9) After voltage check, chip select pulses, then write enable rises.
// (RULE10) Burn request falls, strobe rises one settle time later.
// (RULE11) Conditions held unchanged for the 50 ms hold.
// (RULE12) Burn request rises ending strobe, then write enable falls.
// (RULE13) Chip select returns low as last pulse step.
// (RULE14) Verify after pulse; one retry; second mismatch is an error.
// (RULE15) Strobe and burn request idle during reads.
// (RULE16) Burn request is its own active-low output.
// (RULE17) Result reports pass or failure and read byte.
// (RULE18) Limit 2047 by default, 1023 or 511 by size select.
// (RULE19) Program clears bits only, all eight at once.
// (RULE20) Settle and hold lengths are cycle-count parameters.
// (RULE21) Reset gives idle, request high, select low, enables off.
`timescale 1ns/1ns
`default_nettype none
module eprsq_top
    import eprsq_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
    parameter int unsigned HOLD_CYCLES   = HOLD_CYC,
    parameter int unsigned DEPTH         = FIFO_DEPTH
) (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        req_valid_i,
    input  wire eprsq_req_t  req_i,
    output var  logic        req_ready_o,
    input  wire logic [1:0]  size_sel_i,
    input  wire logic        high_volt_present_i,
    output var  logic        res_valid_o,
    output var  eprsq_res_t  res_o,
    output var  logic        busy_o,
    output var  logic        addr_beyond_limit_n_o,
    output var  logic [10:0] prom_addr_o,
    output var  logic        chip_sel_n_o,
    output var  logic        wr_data_en_o,
    output var  logic        rd_data_en_o,
    output var  logic        burn_request_n_o,
    output var  logic        burn_strobe_o,
    input  wire logic [7:0]  prom_data_i,
    output var  logic [7:0]  prom_data_o,
    output var  logic [7:0]  prom_data_oe_o
);
    localparam int unsigned MAXC = (HOLD_CYCLES > SETTLE_CYCLES) ?
                                   HOLD_CYCLES : SETTLE_CYCLES;
    localparam int unsigned CNT_W = $clog2(MAXC + SYNC_WAIT + 1);

    if (SETTLE_CYCLES < 1 || HOLD_CYCLES < 1 || DEPTH < 2) begin : g_bad_cfg
        $error("eprsq_top: cycle counts must be at least one");
    end

    function automatic logic [11:0] limit_of(input logic [1:0] sel);
        unique case (sel)
            SIZE_2K: limit_of = LIMIT_2K;
            SIZE_1K: limit_of = LIMIT_1K;
            default: limit_of = LIMIT_512;
        endcase
    endfunction : limit_of

    // Pin input filter: take a change once second and third stages agree
    function automatic logic [SYNC_W-1:0] settle(
        input logic [SYNC_W-1:0] s2,
        input logic [SYNC_W-1:0] s3,
        input logic [SYNC_W-1:0] old
    );
        settle = (s3 & ~(s2 ^ s3)) | (old & (s2 ^ s3));
    endfunction : settle

    eprsq_state_t      state_q, state_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    logic              retry_q, retry_d;
    eprsq_req_t        cur_q, cur_d;
    eprsq_res_t        res_d;
    logic              res_valid_d;
    logic [SYNC_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
    logic              hv_ok;
    logic [1:0]        size_ok;
    logic [7:0]        data_ok;
    logic              beyond;
    logic              fifo_valid, fifo_pop;
    logic [REQ_W-1:0]  fifo_data;
    logic              cs_n_d, wde_d, rde_d, burn_n_d, strobe_d, busy_d;
    logic [7:0]        oe_d, pd_d;

    eprsq_fifo #(
        .WIDTH (REQ_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (req_valid_i),
        .in_ready_o  (req_ready_o),
        .in_data_i   (req_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_data)
    );

    assign {size_ok, hv_ok, data_ok} = filt_q;
    assign beyond   = cur_q.addr > limit_of(size_ok); // RULE1 RULE18
    assign fifo_pop = state_q == ST_IDLE;

    always_comb begin
        filt_d      = settle(s2_q, s3_q, filt_q);
        state_d     = state_q;
        cnt_d       = cnt_q + 1'b1;
        retry_d     = retry_q;
        cur_d       = cur_q;
        res_d       = res_o;
        unique case (state_q)
            ST_IDLE: begin
                if (fifo_valid) begin
                    cur_d   = eprsq_req_t'(fifo_data);
                    retry_d = 1'b0;
                    res_d   = '0;
                    state_d = ST_ADDR_CHK;
                end
            end
            ST_ADDR_CHK: begin
                if (beyond) begin
                    res_d.range_err = 1'b1; // RULE2
                    state_d = ST_DONE; // RULE2
                end else begin
                    state_d = cur_q.burn ? ST_HV_CHK : ST_RD_WAIT; // RULE3
                end
            end
            ST_RD_WAIT: begin
                if (cnt_q == CNT_W'(SYNC_WAIT - 1)) begin
                    res_d.rdata = data_ok; // RULE5
                    res_d.pass  = 1'b1; // RULE17
                    state_d     = ST_DONE;
                end
            end
            ST_HV_CHK: begin
                if (!hv_ok) begin
                    res_d.hv_err = 1'b1; // RULE8
                    state_d      = ST_DONE; // RULE8
                end else begin
                    state_d = ST_CS_PULSE; // RULE9
                end
            end
            ST_CS_PULSE: state_d = ST_WDE_ON; // RULE9
            ST_WDE_ON:   state_d = ST_SETTLE;
            ST_SETTLE: begin
                if (cnt_q == CNT_W'(SETTLE_CYCLES - 1)) begin
                    state_d = ST_HOLD; // RULE10 RULE20
                end
            end
            ST_HOLD: begin
                if (cnt_q == CNT_W'(HOLD_CYCLES - 1)) begin
                    state_d = ST_BURN_OFF; // RULE11 RULE20
                end
            end
            ST_BURN_OFF: state_d = ST_WDE_OFF; // RULE12
            ST_WDE_OFF:  state_d = ST_CS_LOW; // RULE13
            ST_CS_LOW:   state_d = ST_VFY_WAIT;
            ST_VFY_WAIT: begin
                if (cnt_q == CNT_W'(SYNC_WAIT - 1)) begin
                    state_d = ST_VFY_CMP;
                end
            end
            ST_VFY_CMP: begin
                res_d.rdata = data_ok;
                if (data_ok == cur_q.wdata) begin
                    res_d.pass = 1'b1; // RULE14
                    state_d    = ST_DONE;
                end else if (!retry_q) begin
                    retry_d = 1'b1; // RULE14
                    state_d = ST_HV_CHK;
                end else begin
                    res_d.verify_err = 1'b1; // RULE14
                    state_d          = ST_DONE;
                end
            end
            ST_DONE: state_d = ST_IDLE;
        endcase
        if (state_d != state_q) begin
            cnt_d = '0;
        end
        res_valid_d = state_d == ST_DONE; // RULE17
        busy_d      = state_d != ST_IDLE;
        // Pin levels follow the state being entered
        cs_n_d   = state_d inside {ST_CS_PULSE, ST_WDE_ON, ST_SETTLE,
                                   ST_HOLD, ST_BURN_OFF, ST_WDE_OFF}; // RULE9 RULE13
        wde_d    = state_d inside {ST_WDE_ON, ST_SETTLE, ST_HOLD,
                                   ST_BURN_OFF}; // RULE6 RULE12
        burn_n_d = !(state_d inside {ST_SETTLE, ST_HOLD}); // RULE10 RULE16
        strobe_d = state_d == ST_HOLD; // RULE10 RULE15
        rde_d    = state_d inside {ST_RD_WAIT, ST_VFY_WAIT}; // RULE5
        // Open collector: pull low only the bits to clear
        oe_d     = wde_d ? ~cur_d.wdata : '0; // RULE7 RULE19
        pd_d     = '0; // RULE19
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q               <= ST_IDLE; // RULE21
            cnt_q                 <= '0;
            retry_q               <= 1'b0;
            cur_q                 <= '0;
            res_o                 <= '0;
            res_valid_o           <= 1'b0;
            busy_o                <= 1'b0;
            s1_q                  <= SYNC_RST;
            s2_q                  <= SYNC_RST;
            s3_q                  <= SYNC_RST;
            filt_q                <= SYNC_RST;
            addr_beyond_limit_n_o <= 1'b1;
            prom_addr_o           <= '0;
            chip_sel_n_o          <= 1'b0; // RULE21
            wr_data_en_o          <= 1'b0; // RULE21
            rd_data_en_o          <= 1'b0; // RULE21
            burn_request_n_o      <= 1'b1; // RULE21
            burn_strobe_o         <= 1'b0;
            prom_data_o           <= '0;
            prom_data_oe_o        <= '0;
        end else begin
            state_q               <= state_d;
            cnt_q                 <= cnt_d;
            retry_q               <= retry_d;
            cur_q                 <= cur_d;
            res_o                 <= res_d;
            res_valid_o           <= res_valid_d;
            busy_o                <= busy_d;
            s1_q                  <= {size_sel_i, high_volt_present_i,
                                      prom_data_i};
            s2_q                  <= s1_q;
            s3_q                  <= s2_q;
            filt_q                <= filt_d;
            addr_beyond_limit_n_o <= !beyond; // RULE1
            prom_addr_o           <= cur_d.addr[PROM_ADDR_W-1:0];
            chip_sel_n_o          <= cs_n_d;
            wr_data_en_o          <= wde_d;
            rd_data_en_o          <= rde_d;
            burn_request_n_o      <= burn_n_d;
            burn_strobe_o         <= strobe_d;
            prom_data_o           <= pd_d;
            prom_data_oe_o        <= oe_d;
        end
    end

    // Helper counters seen only by the checks below
    int unsigned low_cnt, high_cnt;
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_cnt  <= 0;
            high_cnt <= 0;
        end else begin
            low_cnt  <= burn_request_n_o ? 0 :
                        (burn_strobe_o ? low_cnt : low_cnt + 1);
            high_cnt <= burn_strobe_o ? high_cnt + 1 : 0;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence release_seq;
        !burn_strobe_o ##1 !wr_data_en_o && chip_sel_n_o ##1 !chip_sel_n_o;
    endsequence

    AST_RANGE_FLAG: assert property ( // RULE1
        ##1 addr_beyond_limit_n_o == !($past(cur_q.addr) >
                                       limit_of($past(size_ok))))
        else $error("range flag disagrees with address");
    AST_RANGE_ABORT: assert property ( // RULE2
        state_q == ST_ADDR_CHK && beyond |=> res_valid_o && res_o.range_err
        && !res_o.pass && burn_request_n_o && !wr_data_en_o)
        else $error("out-of-range request not abandoned");
    AST_READ_RETURN: assert property ( // RULE5
        $rose(rd_data_en_o) && !cur_q.burn |-> rd_data_en_o [*5] ##1
        res_valid_o && res_o.pass)
        else $error("read did not complete after enable");
    AST_WDE_PROGRAM_ONLY: assert property ( // RULE6
        wr_data_en_o |-> cur_q.burn && busy_o && chip_sel_n_o)
        else $error("write gate open outside a program");
    AST_OPEN_COLLECTOR: assert property ( // RULE7
        prom_data_oe_o != 8'h00 |-> wr_data_en_o && prom_data_o == 8'h00
        && prom_data_oe_o == ~cur_q.wdata)
        else $error("data pins driven wrongly");
    AST_HV_ABORT: assert property ( // RULE8
        state_q == ST_HV_CHK && !hv_ok |=> res_o.hv_err && res_valid_o
        ##1 burn_request_n_o && !busy_o)
        else $error("program continued without high voltage");
    AST_SETTLE_TIME: assert property ( // RULE10
        $rose(burn_strobe_o) |-> !burn_request_n_o
        && low_cnt == SETTLE_CYCLES)
        else $error("strobe rose at wrong settle time");
    AST_HOLD_TIME: assert property ( // RULE11
        $fell(burn_strobe_o) |-> $rose(burn_request_n_o)
        && high_cnt == HOLD_CYCLES && $stable(prom_addr_o))
        else $error("hold interval length wrong");
    AST_RELEASE_ORDER: assert property ( // RULE12
        $rose(burn_request_n_o) |-> release_seq)
        else $error("pulse release order wrong");
    AST_READ_SAFE: assert property ( // RULE15
        rd_data_en_o |-> burn_request_n_o && !burn_strobe_o
        && !wr_data_en_o)
        else $error("programming levels active during read");
    AST_RETRY_ONCE: assert property ( // RULE14
        res_valid_o && res_o.verify_err |-> retry_q && !res_o.pass)
        else $error("verify error without a retry");

endmodule : eprsq_top
`default_nettype wire

// >>> verif/eprsq_prom_model.sv
// EPROM model for the sequencer's far side
`timescale 1ns/1ns
`default_nettype none
module eprsq_prom_model
    import eprsq_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic [10:0] prom_addr_i,
    input  wire logic        chip_sel_n_i,
    input  wire logic        wr_data_en_i,
    input  wire logic        burn_request_n_i,
    input  wire logic        burn_strobe_i,
    input  wire logic [7:0]  prom_data_oe_i,
    input  wire logic [15:0] drop_at_i,
    output wire logic [7:0]  prom_data_o
);
    logic [7:0]  mem [2048];
    logic [15:0] pulse_q  = 16'h0000;
    logic        strobe_q = 1'b0;
    logic        tog_q    = 1'b0;

    initial begin
        foreach (mem[i]) mem[i] = ERASED_BYTE;
    end

    // Write on strobe rise; pulse number drop_at_i is lost
    always @(posedge ref_clk_i) begin
        tog_q    <= ~tog_q;
        strobe_q <= burn_strobe_i;
        if (burn_strobe_i && !strobe_q && !burn_request_n_i) begin
            pulse_q <= pulse_q + 16'h0001;
            if (pulse_q != drop_at_i) begin
                mem[prom_addr_i] <= mem[prom_addr_i] & ~prom_data_oe_i;
            end
        end
    end

    // Pulled-low bits win; deselected pins toggle every cycle
    assign prom_data_o = ~prom_data_oe_i &
        ((!chip_sel_n_i && !wr_data_en_i) ? mem[prom_addr_i] : {8{tog_q}});
endmodule : eprsq_prom_model
`default_nettype wire

// >>> verif/eprsq_top_test.sv
// Self-checking bench for the EPROM program and read sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("wrong value at %0t: got %h expected %h", \
                 $time, got, exp); \
    end \
end
module eprsq_top_test
    import eprsq_pkg::*;
;
    localparam int unsigned SETTLE = 4;
    localparam int unsigned HOLD   = 10;
    typedef struct packed {
        logic [3:0] flags;
        logic [7:0] data;
        logic       cmp;
        logic       inr;
    } eprsq_tb_exp_t;

    logic          ref_clk_i = 1'b0;
    logic          reset_n_i = 1'b1;
    logic          req_valid_i = 1'b0;
    eprsq_req_t    req_i = '0;
    logic [1:0]    size_sel_i = 2'h0;
    logic          high_volt_present_i = 1'b1;
    logic          req_ready_o, res_valid_o, busy_o, addr_beyond_limit_n_o;
    logic          chip_sel_n_o, wr_data_en_o, rd_data_en_o;
    logic          burn_request_n_o, burn_strobe_o;
    logic [10:0]   prom_addr_o;
    logic [7:0]    prom_data_i, prom_data_o, prom_data_oe_o;
    eprsq_res_t    res_o;
    logic [3:0]    res_flags;
    logic [15:0]   drop_at = 16'hffff;
    logic [15:0]   pulses = 16'h0000;
    logic [15:0]   settle_n = 16'h0000;
    logic [15:0]   hold_n = 16'h0000;
    logic          strobe_q = 1'b0;
    logic          wr_q = 1'b0;
    logic          cs_q = 1'b0;
    logic [18:0]   held = '0;
    logic [11:0]   base, lim;
    logic [7:0]    exp_mem [2048];
    eprsq_tb_exp_t exp_q [$];
    int unsigned   err_count = 0;
    int unsigned   samples_checked = 0;

    assign res_flags = {res_o.pass, res_o.range_err, res_o.hv_err,
                        res_o.verify_err};

    eprsq_top #(.SETTLE_CYCLES(SETTLE), .HOLD_CYCLES(HOLD),
                .DEPTH(FIFO_DEPTH)) eprsq_top_i (
        .ref_clk_i, .reset_n_i, .req_valid_i, .req_i, .req_ready_o,
        .size_sel_i, .high_volt_present_i, .res_valid_o, .res_o, .busy_o,
        .addr_beyond_limit_n_o, .prom_addr_o, .chip_sel_n_o, .wr_data_en_o,
        .rd_data_en_o, .burn_request_n_o, .burn_strobe_o, .prom_data_i,
        .prom_data_o, .prom_data_oe_o);

    eprsq_prom_model eprsq_prom_model_i (
        .ref_clk_i, .prom_addr_i(prom_addr_o), .chip_sel_n_i(chip_sel_n_o),
        .wr_data_en_i(wr_data_en_o), .burn_request_n_i(burn_request_n_o),
        .burn_strobe_i(burn_strobe_o), .prom_data_oe_i(prom_data_oe_o),
        .drop_at_i(drop_at), .prom_data_o(prom_data_i));

    initial begin
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    function automatic logic [11:0] limit_of(input logic [1:0] sel);
        return (sel == SIZE_2K) ? LIMIT_2K :
               (sel == SIZE_1K) ? LIMIT_1K : LIMIT_512;
    endfunction : limit_of

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : idle

    task automatic summarize;
        $display("mismatches %0d comparisons %0d", err_count,
                 samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    // Predict the result, then offer the request until taken
    task automatic send(input logic b, input logic [11:0] a,
                        input logic [7:0] w);
        eprsq_tb_exp_t e;
        logic [7:0]    m;
        int            n;
        lim = limit_of(size_sel_i);
        e = '{flags: 4'h4, data: 8'h00, cmp: 1'b0, inr: (a <= lim)};
        if (a <= lim && !b) begin
            e.flags = 4'h8;
            e.data = exp_mem[a[10:0]];
            e.cmp = 1'b1;
        end else if (a <= lim && !high_volt_present_i) begin
            e.flags = 4'h2;
        end else if (a <= lim) begin
            m = exp_mem[a[10:0]];
            for (int t = 0; t < 2; t++) begin
                if (pulses != drop_at) m = m & w;
                pulses++;
                if (m == w) break;
            end
            exp_mem[a[10:0]] = m;
            e.flags = (m == w) ? 4'h8 : 4'h1;
            e.data = m;
            e.cmp = 1'b1;
        end
        exp_q.push_back(e);
        req_valid_i = 1'b1;
        req_i = '{burn: b, addr: a, wdata: w};
        for (n = 0; n < 2000; n++) begin
            @(posedge ref_clk_i);
            if (req_ready_o === 1'b1) break;
        end
        #1;
        if (n == 2000) begin
            err_count++;
            summarize();
        end
    endtask : send

    task automatic drain;
        int n;
        req_valid_i = 1'b0;
        for (n = 0; n < 5000; n++) begin
            if (exp_q.size() == 0 && busy_o === 1'b0) break;
            idle(1);
        end
        if (n == 5000) begin
            err_count++;
            summarize();
        end
        idle(2);
    endtask : drain

    always @(posedge ref_clk_i) begin : result_watch
        eprsq_tb_exp_t e;
        if (res_valid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK(res_valid_o, 1'b0)
            end else begin
                e = exp_q.pop_front();
                `CHK(res_flags, e.flags)
                if (e.cmp) `CHK(res_o.rdata, e.data)
                `CHK(addr_beyond_limit_n_o, e.inr)
            end
        end
    end

    always @(posedge ref_clk_i) begin : pin_watch
        strobe_q <= burn_strobe_o;
        wr_q <= wr_data_en_o;
        cs_q <= chip_sel_n_o;
        settle_n <= (!burn_request_n_o && !burn_strobe_o) ?
                    settle_n + 16'h0001 : 16'h0000;
        hold_n <= burn_strobe_o ? hold_n + 16'h0001 : 16'h0000;
        if (burn_strobe_o && !strobe_q) begin
            `CHK(settle_n, 16'(SETTLE))
            `CHK({wr_data_en_o, chip_sel_n_o}, 2'h3)
            held <= {prom_addr_o, prom_data_oe_o};
        end
        if (burn_strobe_o && strobe_q)
            `CHK({prom_addr_o, prom_data_oe_o, burn_request_n_o},
                 {held, 1'b0})
        if (!burn_strobe_o && strobe_q) begin
            `CHK(hold_n, 16'(HOLD))
            `CHK({burn_request_n_o, wr_data_en_o}, 2'h3)
        end
        if (!wr_data_en_o && wr_q)
            `CHK({chip_sel_n_o, burn_request_n_o}, 2'h3)
        if (!chip_sel_n_o && cs_q) `CHK(wr_data_en_o, 1'b0)
        if (wr_data_en_o !== 1'b1) `CHK(prom_data_oe_o, 8'h00)
        if (rd_data_en_o === 1'b1)
            `CHK({burn_strobe_o, burn_request_n_o}, 2'h1)
        `CHK(prom_data_o, 8'h00)
    end

    initial begin
        repeat (100000) @(posedge ref_clk_i);
        err_count++;
        summarize();
    end

    initial begin
        void'($urandom(33843));
        foreach (exp_mem[i]) exp_mem[i] = ERASED_BYTE;
        #1 reset_n_i = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        `CHK({req_ready_o, busy_o, burn_request_n_o, chip_sel_n_o,
              wr_data_en_o, rd_data_en_o, burn_strobe_o, res_valid_o},
             8'ha0)
        idle(2);
        reset_n_i = 1'b1;
        idle(6);
        // Back-to-back programs fill the queue
        base = 12'($urandom_range(2000, 1100));
        for (int i = 0; i < 9; i++) send(1'b1, base + 12'(i), 8'($urandom));
        req_valid_i = 1'b0;
        idle(2);
        `CHK(req_ready_o, 1'b0)
        drain();
        for (int i = 0; i < 9; i++) send(1'b0, base + 12'(i), 8'h00);
        for (int i = 0; i < 8; i++)
            send(1'b0, 12'($urandom_range(2047)), 8'h00);
        drain();
        // Every size select at its limit and one beyond
        for (int s = 0; s < 4; s++) begin
            size_sel_i = 2'(s);
            idle(6);
            lim = limit_of(size_sel_i);
            send(1'b0, lim, 8'h00);
            send(1'b0, lim + 12'h001, 8'h00);
            send(1'b1, lim + 12'h001, 8'h00);
            send(1'b1, 12'($urandom_range(lim)), 8'($urandom));
            drain();
        end
        size_sel_i = SIZE_2K;
        idle(6);
        send(1'b1, 12'h000, 8'hfe);
        send(1'b1, 12'h000, 8'hff);
        drain();
        drop_at = pulses;
        send(1'b1, 12'h001, 8'($urandom) & 8'h7f);
        drain();
        high_volt_present_i = 1'b0;
        idle(6);
        send(1'b1, 12'h002, 8'h55);
        send(1'b0, 12'h002, 8'h00);
        drain();
        summarize();
    end
endmodule : eprsq_top_test
`default_nettype wire
